// File: hdl/mih_interrupt_handler.sv
// Interrupt handler: pending flags, enables, two priority levels, vector request.
// Assumes the core sequencer pulses instrDone, vectorAck and retiDone on ref_clk,
// and that peripheral event and clear pulses come from logic on ref_clk.
//
// Summary of operation
// - Twenty-two sources, arbitrated on two priority levels.
// - A detected source condition sets that source's pending flag.
// - Flags set even when disabled; disabled flags raise no request.
// - Request waits for instruction end; core then calls the source's vector.
// - Routines end with return; handler then releases the active level.
// - Per-source enables count only while the global enable is one.
// - Global enable zero blocks every source.
// - Some flags clear on vectoring; others need a software clear.
// - Flag still set after return re-requests after one more instruction.
// - Software may set any flag except a level-mode external one; enabled flags then vector as usual.
// - External inputs active low; trigger type at control bits 0 and 2.
// - External pending flags sit at control bits 1 and 3.
// - Edge-mode external flag clears when the core vectors to it.
// - Level-mode external flag mirrors the asserted pin.
`default_nettype none

module mih_interrupt_handler (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // External interrupt pins, active low, asynchronous
    input  wire logic        ext_irq0_n,
    input  wire logic        ext_irq1_n,
    // Peripheral event pulses and software flag writes
    input  wire logic [21:0] periphPendSet,
    input  wire logic [21:0] swPendSet,
    input  wire logic [21:0] swPendClear,
    // Enables and priorities
    input  wire logic        global_irq_enable,
    input  wire logic [21:0] srcEnable,
    input  wire logic [21:0] srcPriorityHigh,
    // Special-function-register port
    input  wire logic [7:0]  sfrAddr,
    input  wire logic        sfrWrite,
    input  wire logic [7:0]  sfrWdata,
    output logic      [7:0]  sfrRdata,
    // Core sequencer handshake
    input  wire logic        instrDone,
    input  wire logic        vectorAck,
    input  wire logic        retiDone,
    output logic             irqReq,
    output logic      [4:0]  irqVector,
    // Status
    output logic      [21:0] pendingFlags,
    output logic      [1:0]  activeLevel
);

    // ------------------------------------------------------------
    // Lowest set index of a request vector
    // ------------------------------------------------------------
    function automatic logic [5:0] mih_pick(input logic [21:0] req);
        logic [5:0] res;
        res = 6'h00;
        for (int i = mih_pkg::NUM_SOURCES - 1; i >= 0; i--) begin
            if (req[i]) begin
                res = {1'b1, 5'(i)};
            end
        end
        return res;
    endfunction : mih_pick

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [1:0]  syncA;
    logic [1:0]  syncB;
    logic [1:0]  pinPrev;
    logic [1:0]  trigEdge;
    logic [1:0]  next_trigEdge;
    logic [21:0] pending;
    logic [21:0] next_pending;
    logic [1:0]  active;
    logic [1:0]  next_active;
    logic        holdOff;
    logic        next_holdOff;
    logic        next_irqReq;
    logic [4:0]  next_irqVector;
    logic [7:0]  next_sfrRdata;

    // ------------------------------------------------------------
    // Pin synchronisers; the second stage and its delayed copy pinPrev feed logic
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            syncA   <= 2'h3;
            syncB   <= 2'h3;
            pinPrev <= 2'h3;
        end else begin
            syncA   <= {ext_irq1_n, ext_irq0_n};
            syncB   <= syncA;
            pinPrev <= syncB;
        end
    end

    // ------------------------------------------------------------
    // Combinational next state
    // ------------------------------------------------------------
    logic        ctrlWr;
    logic [21:0] eligible;
    logic [5:0]  pickHigh;
    logic [5:0]  pickLow;
    logic [21:0] hwSet;
    logic [21:0] hwClr;

    always_comb begin
        ctrlWr = sfrWrite && (sfrAddr == mih_pkg::TIMER_IRQ_CONTROL_ADDR);
        next_trigEdge = trigEdge;
        if (ctrlWr) begin
            next_trigEdge[0] = sfrWdata[mih_pkg::EXT0_TRIGGER_TYPE_BIT];
            next_trigEdge[1] = sfrWdata[mih_pkg::EXT1_TRIGGER_TYPE_BIT];
        end

        // Event sources: peripherals, software, falling pin edges
        hwSet = periphPendSet | swPendSet;
        hwClr = swPendClear;
        if (ctrlWr) begin
            hwSet[mih_pkg::EXT0_SRC] = hwSet[mih_pkg::EXT0_SRC] | sfrWdata[mih_pkg::EXT0_PENDING_BIT];
            hwSet[mih_pkg::EXT1_SRC] = hwSet[mih_pkg::EXT1_SRC] | sfrWdata[mih_pkg::EXT1_PENDING_BIT];
            hwClr[mih_pkg::EXT0_SRC] = hwClr[mih_pkg::EXT0_SRC] | ~sfrWdata[mih_pkg::EXT0_PENDING_BIT];
            hwClr[mih_pkg::EXT1_SRC] = hwClr[mih_pkg::EXT1_SRC] | ~sfrWdata[mih_pkg::EXT1_PENDING_BIT];
        end
        if (trigEdge[0] && pinPrev[0] && !syncB[0]) begin
            hwSet[mih_pkg::EXT0_SRC] = 1'b1;
        end
        if (trigEdge[1] && pinPrev[1] && !syncB[1]) begin
            hwSet[mih_pkg::EXT1_SRC] = 1'b1;
        end
        // Hardware clear on vectoring, only for sources flagged for it and edge-mode external sources
        if (vectorAck) begin
            hwClr[irqVector] = hwClr[irqVector] | mih_pkg::HW_CLEAR_MASK[irqVector];
            if (irqVector == 5'(mih_pkg::EXT0_SRC) && trigEdge[0]) begin
                hwClr[mih_pkg::EXT0_SRC] = 1'b1;
            end
            if (irqVector == 5'(mih_pkg::EXT1_SRC) && trigEdge[1]) begin
                hwClr[mih_pkg::EXT1_SRC] = 1'b1;
            end
        end
        // Set wins over clear so no event is lost; flags set regardless of enables
        next_pending = (pending & ~hwClr) | hwSet;
        // Level mode: flag follows the pin, ignoring writes
        if (!trigEdge[0]) begin
            next_pending[mih_pkg::EXT0_SRC] = ~syncB[0];
        end
        if (!trigEdge[1]) begin
            next_pending[mih_pkg::EXT1_SRC] = ~syncB[1];
        end

        // Arbitration over enabled flags
        eligible = pending & srcEnable & {22{global_irq_enable}};
        pickHigh = mih_pick(eligible & srcPriorityHigh);
        pickLow  = mih_pick(eligible & ~srcPriorityHigh);

        next_irqReq    = 1'b0;
        next_irqVector = irqVector;
        if (!holdOff && !vectorAck && !retiDone) begin
            if (pickHigh[5] && !active[1]) begin
                next_irqReq    = 1'b1;
                next_irqVector = pickHigh[4:0];
            end else if (pickLow[5] && active == 2'h0) begin
                next_irqReq    = 1'b1;
                next_irqVector = pickLow[4:0];
            end
        end

        // Active levels: set on vectoring, innermost released on return
        next_active = active;
        if (vectorAck) begin
            if (srcPriorityHigh[irqVector]) begin
                next_active[1] = 1'b1;
            end else begin
                next_active[0] = 1'b1;
            end
        end else if (retiDone) begin
            if (active[1]) begin
                next_active[1] = 1'b0;
            end else begin
                next_active[0] = 1'b0;
            end
        end

        // One instruction must complete after a return before a new call
        next_holdOff = holdOff;
        if (retiDone) begin
            next_holdOff = 1'b1;
        end else if (instrDone) begin
            next_holdOff = 1'b0;
        end

        // Register read-back; timer bits 7..4 are not part of this block
        next_sfrRdata = 8'h00;
        if (sfrAddr == mih_pkg::TIMER_IRQ_CONTROL_ADDR) begin
            next_sfrRdata[mih_pkg::EXT0_TRIGGER_TYPE_BIT] = trigEdge[0];
            next_sfrRdata[mih_pkg::EXT0_PENDING_BIT]      = pending[mih_pkg::EXT0_SRC];
            next_sfrRdata[mih_pkg::EXT1_TRIGGER_TYPE_BIT] = trigEdge[1];
            next_sfrRdata[mih_pkg::EXT1_PENDING_BIT]      = pending[mih_pkg::EXT1_SRC];
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            trigEdge     <= 2'h0;
            pending      <= mih_pkg::PENDING_RESET;
            active       <= 2'h0;
            holdOff      <= 1'b0;
            irqReq       <= 1'b0;
            irqVector    <= 5'h00;
            sfrRdata     <= mih_pkg::TIMER_IRQ_CONTROL_RESET;
            pendingFlags <= mih_pkg::PENDING_RESET;
            activeLevel  <= 2'h0;
        end else begin
            trigEdge     <= next_trigEdge;
            pending      <= next_pending;
            active       <= next_active;
            holdOff      <= next_holdOff;
            irqReq       <= next_irqReq;
            irqVector    <= next_irqVector;
            sfrRdata     <= next_sfrRdata;
            pendingFlags <= next_pending;
            activeLevel  <= next_active;
        end
    end

endmodule : mih_interrupt_handler

`default_nettype wire

// File: hdl/mih_pkg.sv
// Constants shared by the interrupt handler and its bench.
// Assumes a single system clock and an 8-bit special-function-register port.
`default_nettype none

package mih_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int unsigned NUM_SOURCES = 22;
    localparam int unsigned VEC_W       = 5;

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam logic [7:0] TIMER_IRQ_CONTROL_ADDR = 8'h88;
    localparam int unsigned EXT0_TRIGGER_TYPE_BIT = 0;
    localparam int unsigned EXT0_PENDING_BIT      = 1;
    localparam int unsigned EXT1_TRIGGER_TYPE_BIT = 2;
    localparam int unsigned EXT1_PENDING_BIT      = 3;
    localparam logic [7:0] TIMER_IRQ_CONTROL_RESET = 8'h00;

    // ------------------------------------------------------------
    // Source numbering (lower index wins within one level)
    // ------------------------------------------------------------
    localparam int unsigned EXT0_SRC = 0;
    localparam int unsigned EXT1_SRC = 2;

    // Peripheral flags that hardware clears when the core vectors (value arbitrary)
    localparam logic [21:0] HW_CLEAR_MASK  = 22'h000002;
    localparam logic [21:0] PENDING_RESET  = 22'h000000;

endpackage : mih_pkg

`default_nettype wire

// File: verif/mih_core_model.sv
// Behavioural core sequencer facing the handler.
// Assumes the bench asks for each return itself.
`default_nettype none

module mih_core_model (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Bench controls and handler request
    input  wire logic irqReq,
    input  wire logic retiReq,
    // Handshake towards the handler
    output logic      instrDone,
    output logic      vectorAck,
    output logic      retiDone
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt;

    // An instruction ends every fourth cycle; a call only follows an end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt       <= 2'h0;
            instrDone <= 1'h0;
            vectorAck <= 1'h0;
            retiDone  <= 1'h0;
        end else begin
            cnt       <= cnt + 2'h1;
            instrDone <= (cnt == 2'h3);
            vectorAck <= irqReq && instrDone && !vectorAck;
            retiDone  <= retiReq;
        end
    end
endmodule : mih_core_model

`default_nettype wire

// File: verif/mih_props.sv
// Port checker for the interrupt handler.
// Assumes one clock, ref_clk, and the async active-high rst.
`default_nettype none

module mih_props_chk (
    // Clock, reset and inputs
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        global_irq_enable,
    input wire logic [21:0] srcEnable,
    input wire logic [21:0] srcPriorityHigh,
    input wire logic [21:0] periphPendSet,
    input wire logic [21:0] swPendSet,
    input wire logic [7:0]  sfrAddr,
    input wire logic        instrDone,
    input wire logic        vectorAck,
    input wire logic        retiDone,
    // Outputs watched
    input wire logic        irqReq,
    input wire logic [4:0]  irqVector,
    input wire logic [21:0] pendingFlags,
    input wire logic [1:0]  activeLevel,
    input wire logic [7:0]  sfrRdata
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [21:0] cand;
    logic [21:0] next_cand;
    logic [21:0] setMask;

    // Eligibility one edge back, since the request is registered
    always_comb next_cand = pendingFlags & srcEnable;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) cand <= 22'h0;
        else cand <= next_cand;
    end
    // External flags follow pins in level mode, so they are left out
    assign setMask = (periphPendSet | swPendSet) & 22'h3FFFFA;

    AST_GLOBAL_GATE: assert property (irqReq |-> $past(global_irq_enable))
        else $error("request while globally disabled");
    AST_VEC_ELIGIBLE: assert property (irqReq |-> cand[irqVector])
        else $error("vector not pending and enabled");
    AST_ACK_DROP: assert property (vectorAck |=> !irqReq)
        else $error("request stands after vectoring");
    AST_ACK_LEVEL: assert property (vectorAck |=>
        ($past(srcPriorityHigh[irqVector]) ? activeLevel[1] : activeLevel[0]))
        else $error("active level not taken");
    AST_HIGH_BLOCKS: assert property (activeLevel[1] |-> !irqReq)
        else $error("request inside high routine");
    AST_RETURN_FROM_INTERRUPT_HOLD: assert property (retiDone ##1 !instrDone |=> !irqReq)
        else $error("request before next instruction");
    AST_SET_SEEN: assert property (|setMask |=> (pendingFlags & $past(setMask)) == $past(setMask))
        else $error("set pulse not seen in flags");
    AST_RDATA_MAP: assert property (sfrAddr == 8'h88 |=> sfrRdata[7:4] == 4'h0
        && sfrRdata[1] == $past(pendingFlags[0]) && sfrRdata[3] == $past(pendingFlags[2]))
        else $error("control register flags misplaced");
    COV_LOW_ACK: cover property (vectorAck && activeLevel == 2'h1);
    COV_RETURN_FROM_INTERRUPT: cover property (retiDone);
    COV_EXT0: cover property (vectorAck && irqVector == 5'h00);
endmodule : mih_props_chk

`default_nettype wire

// File: verif/test_mcu_interrupt_handler.sv
// Self-checking bench for the interrupt handler.
// Assumes the core model acks every request and returns on demand.
`default_nettype none

module test_mcu_interrupt_handler;
    timeunit 1ns;
    timeprecision 1ps;
    int          miscompares = 0;
    int          n_tests = 0;
    logic        ref_clk = 1'h0, rst = 1'h1, ext_irq0_n = 1'h1, ext_irq1_n = 1'h1;
    logic        global_irq_enable = 1'h0, sfrWrite = 1'h0, retiReq = 1'h0;
    logic [21:0] periphPendSet = 22'h0, swPendSet = 22'h0, swPendClear = 22'h0;
    logic [21:0] srcEnable = 22'h0, srcPriorityHigh = 22'h000002, pendingFlags;
    logic [7:0]  sfrAddr = 8'h88, sfrWdata = 8'h00, sfrRdata;
    logic        instrDone, vectorAck, retiDone, irqReq;
    logic [4:0]  irqVector;
    logic [1:0]  activeLevel;

    mih_interrupt_handler u_dut (
        .ref_clk           (ref_clk),
        .rst               (rst),
        .ext_irq0_n        (ext_irq0_n),
        .ext_irq1_n        (ext_irq1_n),
        .periphPendSet     (periphPendSet),
        .swPendSet         (swPendSet),
        .swPendClear       (swPendClear),
        .global_irq_enable (global_irq_enable),
        .srcEnable         (srcEnable),
        .srcPriorityHigh   (srcPriorityHigh),
        .sfrAddr           (sfrAddr),
        .sfrWrite          (sfrWrite),
        .sfrWdata          (sfrWdata),
        .sfrRdata          (sfrRdata),
        .instrDone         (instrDone),
        .vectorAck         (vectorAck),
        .retiDone          (retiDone),
        .irqReq            (irqReq),
        .irqVector         (irqVector),
        .pendingFlags      (pendingFlags),
        .activeLevel       (activeLevel)
    );
    mih_core_model u_core (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .irqReq    (irqReq),
        .retiReq   (retiReq),
        .instrDone (instrDone),
        .vectorAck (vectorAck),
        .retiDone  (retiDone)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic chk(input string nm, input logic [21:0] e, input logic [21:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // Bounded wait for the call, then the vector it used
    task automatic vec(input logic [4:0] v);
        for (int i = 0; i < 40 && vectorAck !== 1'h1; i++) tick(1);
        chk("vectorAck", 22'h1, 22'(vectorAck));
        chk("vector", 22'(v), 22'(irqVector));
        tick(1);
    endtask : vec
    task automatic return_from_interrupt();
        retiReq = 1'h1;
        tick(1);
        retiReq = 1'h0;
        tick(2);
    endtask : return_from_interrupt
    task automatic wr(input logic [7:0] d);
        sfrWrite = 1'h1;
        sfrWdata = d;
        tick(1);
        sfrWrite = 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] e);
        tick(1);
        chk("sfrRdata", 22'(e), 22'(sfrRdata));
    endtask : rd
    task automatic give_verdict();
        if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        sfrAddr = 8'h89;
        wr(8'hFF);
        rd(8'h00);
        sfrAddr = 8'h88;
        rd(8'h00);
    endtask : t_regs
    task automatic t_periph();
        periphPendSet[5] = 1'h1;
        tick(1);
        periphPendSet[5] = 1'h0;
        tick(4);
        chk("pend", 22'h000020, pendingFlags);
        srcEnable = 22'h000022;
        tick(4);
        chk("gated", 22'h0, 22'(irqReq));
        global_irq_enable = 1'h1;
        vec(5'h05);
        swPendSet[1] = 1'h1;
        tick(1);
        swPendSet[1] = 1'h0;
        vec(5'h01);
        chk("levels", 22'h3, 22'(activeLevel));
        chk("hwClear", 22'h000020, pendingFlags);
        return_from_interrupt();
        return_from_interrupt();
        vec(5'h05);
        swPendClear[5] = 1'h1;
        tick(1);
        swPendClear[5] = 1'h0;
        return_from_interrupt();
    endtask : t_periph
    // Edge input 0 then level input 1; reserved bits written high
    task automatic t_ext();
        wr(8'hF1);
        rd(8'h01);
        ext_irq0_n = 1'h0;
        tick(4);
        rd(8'h03);
        chk("masked", 22'h0, 22'(irqReq));
        srcEnable[0] = 1'h1;
        vec(5'h00);
        rd(8'h01);
        return_from_interrupt();
        ext_irq0_n = 1'h1;
        ext_irq1_n = 1'h0;
        tick(4);
        chk("mirror", 22'h000004, pendingFlags);
        rd(8'h09);
        ext_irq1_n = 1'h1;
        tick(4);
        chk("release", 22'h0, pendingFlags);
        // Input 1 in edge mode: latches the fall, software clears it
        wr(8'h05);
        ext_irq1_n = 1'h0;
        tick(4);
        rd(8'h0D);
        ext_irq1_n = 1'h1;
        wr(8'h05);
        rd(8'h05);
    endtask : t_ext

    // Clock, main sequence and watchdog
    initial forever #12.5 ref_clk = ~ref_clk;
    initial begin
        tick(2);
        rst = 1'h0;
        tick(1);
        t_regs();
        t_periph();
        t_ext();
        give_verdict();
    end
    initial begin
        repeat (2000) @(posedge ref_clk);
        miscompares++;
        give_verdict();
    end
endmodule : test_mcu_interrupt_handler

bind mih_interrupt_handler mih_props_chk u_chk (
    .ref_clk           (ref_clk),
    .rst               (rst),
    .global_irq_enable (global_irq_enable),
    .srcEnable         (srcEnable),
    .srcPriorityHigh   (srcPriorityHigh),
    .periphPendSet     (periphPendSet),
    .swPendSet         (swPendSet),
    .sfrAddr           (sfrAddr),
    .instrDone         (instrDone),
    .vectorAck         (vectorAck),
    .retiDone          (retiDone),
    .irqReq            (irqReq),
    .irqVector         (irqVector),
    .pendingFlags      (pendingFlags),
    .activeLevel       (activeLevel),
    .sfrRdata          (sfrRdata)
);

`default_nettype wire
